/* logic/gpiop_pkg.sv */
`default_nettype none
package gpiop_pkg;
  // ==========================================================
  // Port geometry
  localparam int unsigned GPIOP_PINS     = 8;
  localparam int unsigned GPIOP_VECTORS  = 7;
  localparam int unsigned GPIOP_VEC_W    = 3;
  localparam int unsigned GPIOP_SYNC_LEN = 2;
  // ==========================================================
  // Reset values
  localparam logic [7:0] GPIOP_LATCH_RST = 8'hFF;
  localparam logic [7:0] GPIOP_DIR_RST   = 8'h00;
  localparam logic [7:0] GPIOP_OPT_RST   = 8'h00;
  localparam logic [2:0] GPIOP_ISEL_RST  = 3'h0;
  localparam logic [6:0] GPIOP_SENS_RST  = 7'h00;
  localparam logic [7:0] GPIOP_ZERO8     = 8'h00;
  localparam logic [6:0] GPIOP_ZERO7     = 7'h00;
  // ==========================================================
  // Sensitivity encoding per vector
  localparam logic GPIOP_SENS_FALL = 1'b0;
  localparam logic GPIOP_SENS_RISE = 1'b1;
  // Pin-select code meaning no interrupt
  localparam logic [2:0] GPIOP_ISEL_NONE = 3'h0;
endpackage : gpiop_pkg
`default_nettype wire

/* logic/gpiop_sync.sv */
`default_nettype none
module gpiop_sync
  import gpiop_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Asynchronous pin levels
  input  wire logic [GPIOP_PINS-1:0] async_i,
  // Synchronised levels
  output logic      [GPIOP_PINS-1:0] sync_o
);
  logic [GPIOP_PINS-1:0] stage1;
  logic [GPIOP_PINS-1:0] stage2;

  // Reset to high matches the idle pull-up level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= GPIOP_LATCH_RST;
      stage2 <= GPIOP_LATCH_RST;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule : gpiop_sync
`default_nettype wire

/* logic/gpiop_port.sv */
// Operation
// R1: Bit x of each register controls pin x
// R2: Direction clear: input, read returns pin level
// R3: Input option bit selects floating or pull-up
// R4: Input-mode latch writes leave pin unchanged
// R5: Nonzero pin select makes pin interrupt source; code also needs direction clear and option bit set
// R6: Qualifying edge raises request on pin's vector
// R7: Per-vector falling or rising edge sensitivity
// R8: Seven vectors, several pins may share one
// R9: Shared pins combined, low pin masks others
// R10: Vector fetch clears pending request latch
// R11: Sensitivity change clears vector pending request
// R12: Disabled interrupt forces detector input to one
// R13: Software enable sequence avoids spurious requests
// R14: Software disable sequence avoids spurious requests
// R15: Direction set: drive latch, read returns latch
// R16: Output option: push-pull or open-drain drive
// R17: Alternate output overrides port, read gives pin
// R18: Input plus alternate output reads alternate
// R19: Output plus alternate input sees latch value
// R20: Alternate input wants floating, no interrupt
// R21: Request only delivered when CPU mask clear
// R22: Pins pass two flip-flops before use
`default_nettype none
module gpiop_port
  import gpiop_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Latch access
  input  wire logic                     latch_we_i,
  input  wire logic [GPIOP_PINS-1:0]    latch_wdata_i,
  output logic      [GPIOP_PINS-1:0]    latch_rdata_o,
  // Configuration
  input  wire logic                     dir_we_i,
  input  wire logic [GPIOP_PINS-1:0]    dir_wdata_i,
  input  wire logic                     opt_we_i,
  input  wire logic [GPIOP_PINS-1:0]    opt_wdata_i,
  input  wire logic                     isel_we_i,
  input  wire logic [GPIOP_PINS*3-1:0]  isel_wdata_i,
  input  wire logic                     sens_we_i,
  input  wire logic [GPIOP_VECTORS-1:0] sens_wdata_i,
  // Configuration readback
  output logic      [GPIOP_PINS-1:0]    dir_o,
  output logic      [GPIOP_PINS-1:0]    opt_o,
  output logic      [GPIOP_VECTORS-1:0] sens_o,
  // Alternate functions
  input  wire logic [GPIOP_PINS-1:0]    alt_oe_i,
  input  wire logic [GPIOP_PINS-1:0]    alt_out_i,
  output logic      [GPIOP_PINS-1:0]    alt_in_o,
  // CPU interrupt side
  input  wire logic                     cpu_mask_i,
  input  wire logic [GPIOP_VECTORS-1:0] vec_fetch_i,
  output logic      [GPIOP_VECTORS-1:0] pending_o,
  output logic      [GPIOP_VECTORS-1:0] ext_irq_line_o,
  // Pins
  input  wire logic [GPIOP_PINS-1:0]    pin_i,
  output logic      [GPIOP_PINS-1:0]    pin_o,
  output logic      [GPIOP_PINS-1:0]    pin_oe_o,
  output logic      [GPIOP_PINS-1:0]    pull_up_o
);
  // ==========================================================
  // Port registers
  logic [GPIOP_PINS-1:0]    pin_data_latch;
  logic [GPIOP_PINS-1:0]    direction_select;
  logic [GPIOP_PINS-1:0]    pin_option_select;
  logic [GPIOP_VEC_W-1:0]   interrupt_pin_select [GPIOP_PINS];
  logic [GPIOP_VECTORS-1:0] interrupt_sensitivity_control;
  logic [GPIOP_VECTORS-1:0] pending;
  logic [GPIOP_VECTORS-1:0] det_prev;
  logic [GPIOP_PINS-1:0]    pin_sync;

  // Decoding used by several pin slices
  function automatic logic gpiop_is_irq(input logic [GPIOP_VEC_W-1:0] sel);
    gpiop_is_irq = (sel != GPIOP_ISEL_NONE);
  endfunction : gpiop_is_irq

  // ==========================================================
  // Pin synchronisers
  gpiop_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  ); // see R22

  // ==========================================================
  // Register writes
  // Latch is written regardless of direction; in input mode the
  // stored value simply does not reach the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_data_latch <= GPIOP_LATCH_RST;
    end else if (latch_we_i) begin
      pin_data_latch <= latch_wdata_i; // see R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_select  <= GPIOP_DIR_RST;
      pin_option_select <= GPIOP_OPT_RST;
    end else begin
      if (dir_we_i) begin
        direction_select <= dir_wdata_i; // see R1
      end
      if (opt_we_i) begin
        pin_option_select <= opt_wdata_i; // see R1
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_sensitivity_control <= GPIOP_SENS_RST;
    end else if (sens_we_i) begin
      interrupt_sensitivity_control <= sens_wdata_i; // see R7
    end
  end

  // ==========================================================
  // Per-pin datapath
  logic [GPIOP_PINS-1:0] eff_out;
  logic [GPIOP_PINS-1:0] eff_val;
  logic [GPIOP_PINS-1:0] next_pin_oe;
  logic [GPIOP_PINS-1:0] next_pin;
  logic [GPIOP_PINS-1:0] next_pull;
  logic [GPIOP_PINS-1:0] next_rdata;
  logic [GPIOP_PINS-1:0] next_alt_in;
  logic [GPIOP_PINS-1:0] irq_en;
  logic [GPIOP_PINS-1:0] det_in;

  genvar gp;
  generate
    for (gp = 0; gp < GPIOP_PINS; gp++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          interrupt_pin_select[gp] <= GPIOP_ISEL_RST;
        end else if (isel_we_i) begin
          interrupt_pin_select[gp] <= isel_wdata_i[gp*3 +: 3]; // see R5
        end
      end

      // Peripheral output wins over port programming
      assign eff_out[gp] = alt_oe_i[gp] | direction_select[gp]; // see R17
      assign eff_val[gp] = alt_oe_i[gp] ? alt_out_i[gp]
                                        : pin_data_latch[gp]; // see R15
      // Open drain only drives lows; alternate output is push-pull
      assign next_pin_oe[gp] = eff_out[gp]
          & (alt_oe_i[gp] | pin_option_select[gp]
             | ~pin_data_latch[gp]); // see R16
      assign next_pin[gp] = eff_val[gp];
      assign next_pull[gp] = ~eff_out[gp] & pin_option_select[gp]; // see R3
      // Input with alternate output reads back the peripheral value
      assign next_rdata[gp] =
          alt_oe_i[gp]           ? (direction_select[gp] ? pin_sync[gp]
                                                         : alt_out_i[gp])
        : direction_select[gp]   ? pin_data_latch[gp]
                                 : pin_sync[gp]; // see R2 R15 R17 R18
      // Output mode hands the latch level to the peripheral input
      assign next_alt_in[gp] = direction_select[gp] ? pin_data_latch[gp]
                                                    : pin_sync[gp]; // see R19
      assign irq_en[gp] = gpiop_is_irq(interrupt_pin_select[gp])
                        & ~direction_select[gp]
                        & pin_option_select[gp]; // see R5
      // Forced high when disabled, so enabling on a low pin can fire
      assign det_in[gp] = irq_en[gp] ? pin_sync[gp] : 1'b1; // see R12
    end
  endgenerate

  // ==========================================================
  // Vector combining and edge detection
  logic [GPIOP_VECTORS-1:0] vec_level;
  logic [GPIOP_VECTORS-1:0] rise;
  logic [GPIOP_VECTORS-1:0] fall;
  logic [GPIOP_VECTORS-1:0] hit;
  logic [GPIOP_VECTORS-1:0] sens_chg;
  logic [GPIOP_VECTORS-1:0] next_pending;

  genvar gv;
  generate
    for (gv = 0; gv < GPIOP_VECTORS; gv++) begin : g_vec
      logic [GPIOP_PINS-1:0] member;
      for (gp = 0; gp < GPIOP_PINS; gp++) begin : g_mem
        assign member[gp] =
            (interrupt_pin_select[gp] == GPIOP_VEC_W'(gv + 1)); // see R8
      end
      // AND of all members: one low pin hides edges of the rest
      assign vec_level[gv] = &(det_in | ~member); // see R9
      assign rise[gv] = vec_level[gv] & ~det_prev[gv];
      assign fall[gv] = ~vec_level[gv] & det_prev[gv];
      assign hit[gv] =
          (interrupt_sensitivity_control[gv] == GPIOP_SENS_RISE) ? rise[gv]
                                                                 : fall[gv];
      assign sens_chg[gv] = sens_we_i
          & (sens_wdata_i[gv] != interrupt_sensitivity_control[gv]);
      // A new edge outranks a fetch clear in the same cycle
      assign next_pending[gv] = hit[gv]
          | (pending[gv] & ~vec_fetch_i[gv]
             & ~sens_chg[gv]); // see R6 R10 R11
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_prev <= {GPIOP_VECTORS{1'b1}};
      pending  <= GPIOP_ZERO7;
    end else begin
      det_prev <= vec_level;
      pending  <= next_pending; // see R6
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o          <= GPIOP_LATCH_RST;
      pin_oe_o       <= GPIOP_ZERO8;
      pull_up_o      <= GPIOP_ZERO8;
      latch_rdata_o  <= GPIOP_ZERO8;
      alt_in_o       <= GPIOP_ZERO8;
      ext_irq_line_o <= GPIOP_ZERO7;
    end else begin
      pin_o          <= next_pin;
      pin_oe_o       <= next_pin_oe; // see R16
      pull_up_o      <= next_pull;
      latch_rdata_o  <= next_rdata;
      alt_in_o       <= next_alt_in;
      ext_irq_line_o <= next_pending & {GPIOP_VECTORS{~cpu_mask_i}}; // see R21
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o     <= GPIOP_DIR_RST;
      opt_o     <= GPIOP_OPT_RST;
      sens_o    <= GPIOP_SENS_RST;
      pending_o <= GPIOP_ZERO7;
    end else begin
      dir_o     <= dir_we_i ? dir_wdata_i : direction_select;
      opt_o     <= opt_we_i ? opt_wdata_i : pin_option_select;
      sens_o    <= sens_we_i ? sens_wdata_i : interrupt_sensitivity_control;
      pending_o <= next_pending;
    end
  end
endmodule : gpiop_port
`default_nettype wire

/* dv/gpiop_port_asserts.sv */
`default_nettype none
module gpiop_port_asserts (
  // Clock, reset and stimulus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       sens_we_i,
  input wire logic [7:0] alt_oe_i,
  input wire logic       cpu_mask_i,
  input wire logic [6:0] vec_fetch_i,
  input wire logic [7:0] pin_i,
  // Design outputs
  input wire logic [7:0] dir_o,
  input wire logic [7:0] opt_o,
  input wire logic [6:0] pending_o,
  input wire logic [6:0] ext_irq_line_o,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pull_up_o,
  input wire logic [7:0] latch_rdata_o
);
  // ==========================================================
  // Pins that stayed plain inputs over the read path depth
  logic [7:0] busy1;
  logic [7:0] busy2;
  always_ff @(posedge clk_i) begin
    busy1 <= dir_o | alt_oe_i;
    busy2 <= busy1;
  end
  wire logic [7:0] in_mask = ~(dir_o | alt_oe_i | busy1 | busy2);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_input_undriven: assert property (
    $stable(dir_o) && $stable(alt_oe_i) |->
    (pin_oe_o & ~dir_o & ~alt_oe_i) == 8'h00) else $error("input driven");
  a_open_drain: assert property (
    $stable(opt_o) && $stable(alt_oe_i) |->
    (pin_oe_o & pin_o & ~opt_o & ~alt_oe_i) == 8'h00) else $error("od high");
  a_pull_mode: assert property (
    $stable(dir_o) && $stable(opt_o) && $stable(alt_oe_i) |->
    ((pull_up_o ^ (~dir_o & opt_o)) & ~alt_oe_i) == 8'h00)
    else $error("pull-up wrong");
  a_irq_masked: assert property (
    $past(cpu_mask_i) |-> ext_irq_line_o == 7'h00) else $error("irq leak");
  a_irq_follows: assert property (
    !$past(cpu_mask_i) |-> ext_irq_line_o == pending_o)
    else $error("irq lost");
  a_pend_hold: assert property (
    vec_fetch_i == 7'h00 && !sens_we_i |=>
    (pending_o & $past(pending_o)) == $past(pending_o))
    else $error("pending dropped");
  a_fetch_clear: assert property (
    vec_fetch_i != 7'h00 && $stable(pin_i) |=>
    (pending_o & $past(vec_fetch_i)) == 7'h00) else $error("fetch kept");
  a_sync_delay: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3) |->
    ((latch_rdata_o ^ $past(pin_i, 3)) & in_mask) == 8'h00)
    else $error("pin read timing");
endmodule : gpiop_port_asserts
`default_nettype wire

/* dv/gpiop_pin_model.sv */
`default_nettype none
module gpiop_pin_model (
  // Design side
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] pull_up_o,
  // Far-side drivers
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] lvl_o
);
  // ==========================================================
  // A released wire wanders, so a stale level never passes
  logic [7:0] last = 8'h00;
  always @(posedge clk_i) last <= lvl_o;
  assign lvl_o = pin_oe_o & pin_o | ~pin_oe_o & (ext_en_i & ext_val_i |
    ~ext_en_i & (pull_up_o | ~last));
endmodule : gpiop_pin_model
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  localparam int DIR = 0, OPT = 1, ISEL = 2, SENS = 3, LAT = 4;
  logic        clk_i = 1'b0, rst_i = 1'b1, cpu_mask_i = 1'b0;
  logic        latch_we_i = 1'b0, dir_we_i = 1'b0, opt_we_i = 1'b0;
  logic        isel_we_i = 1'b0, sens_we_i = 1'b0;
  logic [7:0]  latch_wdata_i = 8'h00, dir_wdata_i = 8'h00;
  logic [7:0]  opt_wdata_i = 8'h00, alt_oe_i = 8'h00, alt_out_i = 8'h00;
  logic [23:0] isel_wdata_i = 24'h000000;
  logic [6:0]  sens_wdata_i = 7'h00, vec_fetch_i = 7'h00;
  logic [7:0]  ext_en = 8'hFF, ext_val = 8'hFF, pin_i, pin_o, pin_oe_o;
  logic [7:0]  latch_rdata_o, dir_o, opt_o, alt_in_o, pull_up_o;
  logic [6:0]  sens_o, pending_o, ext_irq_line_o;
  int          fails = 0, n_compared = 0;
  gpiop_port dut_u (.*);
  gpiop_pin_model pins_u (.clk_i, .pin_o, .pin_oe_o, .pull_up_o,
    .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));
  always #5 clk_i = ~clk_i;
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input int k, input logic [23:0] v);
    {dir_we_i, opt_we_i, isel_we_i, sens_we_i, latch_we_i} <= 5'h10 >> k;
    {dir_wdata_i, opt_wdata_i, latch_wdata_i} <= {3{v[7:0]}};
    isel_wdata_i <= v;
    sens_wdata_i <= v[6:0];
    cyc(1);
    {dir_we_i, opt_we_i, isel_we_i, sens_we_i, latch_we_i} <= 5'h00;
    cyc(1);
  endtask : wr
  task automatic wait_pend(input logic [6:0] m);
    int i;
    for (i = 0; i < 20 && (pending_o & m) !== m; i++) cyc(1);
    if (i == 20) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_pend
  task automatic fetch(input logic [6:0] m);
    vec_fetch_i <= m;
    cyc(1);
    vec_fetch_i <= 7'h00;
    cyc(2);
  endtask : fetch
  task automatic t_out;
    ext_en <= 8'h00;
    wr(LAT, 24'hA5);
    wr(OPT, 24'h0F);
    wr(DIR, 24'hFF);
    cyc(2);
    chk(pin_oe_o, 8'h5F);
    chk(pin_o & pin_oe_o, 8'h05);
    chk(latch_rdata_o, 8'hA5);
    $display("output test done");
  endtask : t_out
  task automatic t_in;
    ext_en <= 8'hFF;
    ext_val <= 8'h3C;
    wr(DIR, 24'h00);
    wr(OPT, 24'hF0);
    wr(LAT, 24'h00);
    cyc(3);
    chk(latch_rdata_o, 8'h3C);
    chk(pull_up_o, 8'hF0);
    chk(pin_oe_o, 8'h00);
    {ext_en, alt_out_i, alt_oe_i} <= 24'h00_96_0F;
    cyc(4);
    chk(pin_oe_o, 8'h0F);
    chk(latch_rdata_o, 8'hF6);
    {ext_en, ext_val, alt_oe_i} <= 24'h0F_00_00;
    wr(LAT, 24'h0F);
    wr(DIR, 24'hFF);
    cyc(3);
    chk(alt_in_o, 8'h0F);
    // Floating input without interrupt hands the pin to the peripheral
    {ext_en, ext_val} <= 16'hFF_5A;
    wr(DIR, 24'h00);
    wr(OPT, 24'h00);
    cyc(3);
    chk(alt_in_o, 8'h5A);
    $display("input and alternate test done");
  endtask : t_in
  task automatic t_vec;
    {ext_en, ext_val} <= 16'hFFFF;
    wr(DIR, 24'h00);
    wr(OPT, 24'h00);
    wr(ISEL, 24'h1F58D1);
    cpu_mask_i <= 1'b1;
    wr(SENS, 24'h7F);
    wr(OPT, 24'hFF);
    wr(SENS, 24'h55);
    cpu_mask_i <= 1'b0;
    cyc(4);
    chk({1'b0, pending_o}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      ext_val <= ~(8'h01 << k);
      cyc(5);
      ext_val <= 8'hFF;
      cyc(5);
      chk({1'b0, pending_o}, 8'h7F & (8'h01 << k));
      chk({1'b0, ext_irq_line_o}, 8'h7F & (8'h01 << k));
      fetch(7'h7F);
      chk({1'b0, pending_o}, 8'h00);
    end
    $display("vector test done");
  endtask : t_vec
  task automatic t_share;
    wr(ISEL, 24'h000009);
    wr(SENS, 24'h01);
    ext_val <= 8'hFD;
    cyc(5);
    ext_val <= 8'hFC;
    cyc(5);
    ext_val <= 8'hFD;
    cyc(5);
    chk({1'b0, pending_o}, 8'h00);
    cpu_mask_i <= 1'b1;
    ext_val <= 8'hFF;
    wait_pend(7'h01);
    chk({1'b0, ext_irq_line_o}, 8'h00);
    wr(SENS, 24'h00);
    chk({1'b0, pending_o}, 8'h00);
    chk({1'b0, sens_o}, 8'h00);
    ext_val <= 8'hFC;
    wait_pend(7'h01);
    fetch(7'h01);
    wr(OPT, 24'h00);
    wr(SENS, 24'h01);
    cpu_mask_i <= 1'b0;
    cyc(4);
    chk({1'b0, pending_o}, 8'h00);
    wr(SENS, 24'h00);
    wr(OPT, 24'h03);
    wait_pend(7'h01);
    $display("shared vector test done");
  endtask : t_share
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
    chk(dir_o, 8'h00);
    chk(pull_up_o, 8'h00);
    t_out();
    t_in();
    t_vec();
    t_share();
    report_and_stop();
  end
endmodule : testbench
bind gpiop_port gpiop_port_asserts chk_u (.*);
`default_nettype wire
